// ---- hdl/scfpt_flash_seq.sv ----
/*
 * Serial configuration flash power and self-timed cycle model.
 * Assumes a 10 MHz system clock and a host-driven serial clock that
 * runs only inside frames; host keeps its own clock-rate limits.
 */
// Function
// - Select low: enabled and active power
// - Deselected: stay active until cycles finish
// - Program cycle 1.5 ms, 2.5 ms large
// - Status write cycle 5 ms typical
// - Bulk erase within density maximum
// - Sector erase 2 s typical
// - Erase starts right at deselect
// - Busy flag set during cycle; latch clears
`timescale 1ns/10ps

module scfpt_flash_seq
    import scfpt_pkg::*;
#(
    parameter int unsigned DENSITY = 0,
    parameter logic [7:0]  OPC_WREN = 8'h06,
    parameter logic [7:0]  OPC_WRDI = 8'h04,
    parameter logic [7:0]  OPC_WSR  = 8'h01,
    parameter logic [7:0]  OPC_PROG = 8'h02,
    parameter logic [7:0]  OPC_SE   = 8'hd8,
    parameter logic [7:0]  OPC_BE   = 8'hc7,
    parameter int unsigned PROG_CYC = ((DENSITY == DENSITY_MAX) ?
                                       T_PROG_LG_US : T_PROG_US) * CLK_PER_US,
    parameter int unsigned WSR_CYC  = T_WSR_US * CLK_PER_US,
    parameter int unsigned SE_CYC   = T_SE_S * CLK_HZ,
    parameter int unsigned BE_CYC   = T_BE_S[DENSITY] * CLK_HZ
)
(
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       serial_clock_line,
    input  wire logic       flash_select_low,
    input  wire logic       serial_data_in,
    output logic            flash_enabled,
    output logic            active_power,
    output logic            standby_power,
    output logic            write_in_progress,
    output logic            write_enable_latch,
    output logic [1:0]      cycle_kind
);

    generate
        if (DENSITY > DENSITY_MAX)
            $error("DENSITY out of range");
        if (PROG_CYC == 0 || WSR_CYC == 0 || SE_CYC == 0 || BE_CYC == 0)
            $error("Cycle counts must be nonzero");
    endgenerate

    localparam logic [31:0] PROG_LOAD = PROG_CYC[31:0];
    localparam logic [31:0] WSR_LOAD  = WSR_CYC[31:0];
    localparam logic [31:0] SE_LOAD   = SE_CYC[31:0];
    localparam logic [31:0] BE_LOAD   = BE_CYC[31:0];

    typedef struct packed {
        logic         cs_meta;
        logic         cs_sync;
        logic         cs_prev;
        scfpt_state_e st;
        logic         wel;
        logic         wip;
        scfpt_kind_e  kind;
        logic         enabled;
        logic         active;
        logic         standby;
        logic         start;
        logic [31:0]  load;
    } scfpt_seq_s;

    scfpt_seq_s s_reg;
    scfpt_seq_s s_next;

    scfpt_op_if  opif ();
    scfpt_tmr_if tif ();

    logic frame_end;
    logic op_ok;
    logic is_write_op;

    scfpt_op_shift u_shift (
        .serial_clock_line (serial_clock_line),
        .arst_n            (arst_n),
        .flash_select_low  (flash_select_low),
        .serial_data_in    (serial_data_in),
        .opif              (opif)
    );

    scfpt_cycle_timer u_timer (
        .clock  (clock),
        .arst_n (arst_n),
        .tif    (tif)
    );

    // Opcode is quasi-static once select is seen high: link clock stopped
    assign frame_end   = s_reg.cs_sync & ~s_reg.cs_prev;
    assign op_ok       = frame_end & opif.valid & (s_reg.st == SCFPT_IDLE);
    assign is_write_op = (opif.opcode == OPC_PROG) ||
                         (opif.opcode == OPC_WSR)  ||
                         (opif.opcode == OPC_SE)   ||
                         (opif.opcode == OPC_BE);

    always_comb
    begin
        s_next         = s_reg;
        s_next.cs_meta = flash_select_low;
        s_next.cs_sync = s_reg.cs_meta;
        s_next.cs_prev = s_reg.cs_sync;
        s_next.start   = 1'b0;

        case (s_reg.st)
            SCFPT_IDLE:
            begin
                if (op_ok && opif.opcode == OPC_WREN)
                    s_next.wel = 1'b1;
                else if (op_ok && opif.opcode == OPC_WRDI)
                    s_next.wel = 1'b0;
                else if (op_ok && is_write_op && s_reg.wel)
                begin
                    // Cycle begins on the deselect that ends the frame
                    s_next.start = 1'b1;
                    s_next.wip   = 1'b1;
                    s_next.wel   = 1'b0;
                    s_next.st    = SCFPT_BUSY;
                    case (opif.opcode)
                        OPC_PROG:
                        begin
                            s_next.kind = SCFPT_K_PROG;
                            s_next.load = PROG_LOAD;
                        end
                        OPC_WSR:
                        begin
                            s_next.kind = SCFPT_K_WSR;
                            s_next.load = WSR_LOAD;
                        end
                        OPC_SE:
                        begin
                            s_next.kind = SCFPT_K_SE;
                            s_next.load = SE_LOAD;
                        end
                        default:
                        begin
                            s_next.kind = SCFPT_K_BE;
                            s_next.load = BE_LOAD;
                        end
                    endcase
                end
            end
            SCFPT_BUSY:
            begin
                // Every command, enable and disable included, is ignored while busy
                if (tif.done)
                begin
                    s_next.wip = 1'b0;
                    s_next.st  = SCFPT_IDLE;
                end
            end
            default:
                s_next.st = SCFPT_IDLE;
        endcase

        s_next.enabled = ~s_next.cs_sync;
        s_next.active  = ~s_next.cs_sync | s_next.wip;
        s_next.standby = s_next.cs_sync & ~s_next.wip;
    end

    // Select idles high, so the synchroniser resets deselected
    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n)
        begin
            s_reg         <= '0;
            s_reg.cs_meta <= 1'b1;
            s_reg.cs_sync <= 1'b1;
            s_reg.cs_prev <= 1'b1;
            s_reg.standby <= 1'b1;
        end
        else
            s_reg <= s_next;

    assign tif.start = s_reg.start;
    assign tif.load  = s_reg.load;

    assign flash_enabled      = s_reg.enabled;
    assign active_power       = s_reg.active;
    assign standby_power      = s_reg.standby;
    assign write_in_progress  = s_reg.wip;
    assign write_enable_latch = s_reg.wel;
    assign cycle_kind         = s_reg.kind;

    sequence s_frame_end;
        s_reg.cs_sync && !s_reg.cs_prev;
    endsequence

    sequence s_cycle_start;
        s_reg.start && s_reg.wip;
    endsequence

    property p_select_active;
        @(posedge clock) disable iff (!arst_n)
        !s_reg.cs_sync |-> flash_enabled && active_power && !standby_power;
    endproperty
    a_select_active: assert property (p_select_active)
        else $error("Selected flash not enabled and active");

    property p_stay_active;
        @(posedge clock) disable iff (!arst_n)
        (s_reg.cs_sync && tif.busy) |-> active_power && !flash_enabled;
    endproperty
    a_stay_active: assert property (p_stay_active)
        else $error("Flash left active power during a cycle");

    property p_erase_immediate;
        @(posedge clock) disable iff (!arst_n)
        (s_frame_end and (s_reg.st == SCFPT_IDLE) && opif.valid &&
            s_reg.wel && (opif.opcode == OPC_SE || opif.opcode == OPC_BE))
        |=> s_cycle_start ##1 tif.busy;
    endproperty
    a_erase_immediate: assert property (p_erase_immediate)
        else $error("Erase cycle did not start at deselect");

    property p_busy_flags;
        @(posedge clock) disable iff (!arst_n)
        s_cycle_start |-> !write_enable_latch ##1 write_in_progress [*2];
    endproperty
    a_busy_flags: assert property (p_busy_flags)
        else $error("Busy or latch flag wrong at cycle start");

    property p_wip_clears;
        @(posedge clock) disable iff (!arst_n)
        tif.done |=> !write_in_progress && s_reg.st == SCFPT_IDLE;
    endproperty
    a_wip_clears: assert property (p_wip_clears)
        else $error("Busy flag did not clear after cycle");

    property p_prog_time;
        @(posedge clock) disable iff (!arst_n)
        (s_reg.start && s_reg.kind == SCFPT_K_PROG) |->
            s_reg.load == PROG_LOAD;
    endproperty
    a_prog_time: assert property (p_prog_time)
        else $error("Program cycle length wrong");

    property p_wsr_time;
        @(posedge clock) disable iff (!arst_n)
        (s_reg.start && s_reg.kind == SCFPT_K_WSR) |->
            s_reg.load == WSR_LOAD;
    endproperty
    a_wsr_time: assert property (p_wsr_time)
        else $error("Status write cycle length wrong");

    property p_be_time;
        @(posedge clock) disable iff (!arst_n)
        (s_reg.start && s_reg.kind == SCFPT_K_BE) |->
            s_reg.load == BE_LOAD;
    endproperty
    a_be_time: assert property (p_be_time)
        else $error("Bulk erase cycle length wrong");

    property p_se_time;
        @(posedge clock) disable iff (!arst_n)
        (s_reg.start && s_reg.kind == SCFPT_K_SE) |->
            s_reg.load == SE_LOAD;
    endproperty
    a_se_time: assert property (p_se_time)
        else $error("Sector erase cycle length wrong");

    property p_standby;
        @(posedge clock) disable iff (!arst_n)
        standby_power |-> s_reg.cs_sync && !write_in_progress &&
            !active_power;
    endproperty
    a_standby: assert property (p_standby)
        else $error("Standby while selected or busy");

    property p_standby_entry;
        @(posedge clock) disable iff (!arst_n)
        // First synchroniser stage is never read here: it may be metastable
        $fell(write_in_progress) && s_reg.cs_sync |-> standby_power;
    endproperty
    a_standby_entry: assert property (p_standby_entry)
        else $error("Standby not entered when cycle finished");

endmodule : scfpt_flash_seq

// ---- hdl/scfpt_pkg.sv ----
/*
 * Shared constants for the serial configuration flash timing model:
 * clock rate, self-timed cycle durations, opcode width, cycle kinds, states.
 * Assumes a 10 MHz system clock; durations are typical figures.
 */
package scfpt_pkg;

    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned CLK_PER_US   = CLK_HZ / 1_000_000;
    localparam int unsigned DENSITY_MAX  = 4;

    // Program cycle, microseconds (typical)
    localparam int unsigned T_PROG_US    = 1500;
    localparam int unsigned T_PROG_LG_US = 2500;
    // Status write cycle, microseconds (typical)
    localparam int unsigned T_WSR_US     = 5000;
    // Sector erase, seconds (typical)
    localparam int unsigned T_SE_S       = 2;
    // Bulk erase per density, seconds (typical)
    localparam int unsigned T_BE_S [5]   = '{3, 5, 17, 68, 105};

    localparam int unsigned CNT_W        = 32;
    localparam int unsigned OP_W         = 8;
    localparam logic [3:0]  OP_BITS      = 4'h8;

    typedef enum logic [1:0] {
        SCFPT_K_PROG,
        SCFPT_K_WSR,
        SCFPT_K_SE,
        SCFPT_K_BE
    } scfpt_kind_e;

    typedef enum logic [0:0] {
        SCFPT_IDLE,
        SCFPT_BUSY
    } scfpt_state_e;

endpackage : scfpt_pkg

// ---- hdl/scfpt_if.sv ----
/*
 * Carriers between the flash sequencer and its two helpers.
 * Opcode carrier crosses from link clock; held stable while deselected.
 */
`timescale 1ns/10ps

interface scfpt_op_if;
    logic [7:0] opcode;
    logic       valid;
    modport producer (output opcode, output valid);
    modport consumer (input  opcode, input  valid);
endinterface : scfpt_op_if

interface scfpt_tmr_if;
    logic        start;
    logic [31:0] load;
    logic        busy;
    logic        done;
    modport ctrl  (output start, output load, input  busy, input  done);
    modport timer (input  start, input  load, output busy, output done);
endinterface : scfpt_tmr_if

// ---- hdl/scfpt_op_shift.sv ----
/*
 * Link-side opcode capture, clocked by the host serial clock.
 * Assumes the serial clock runs only while select is low.
 */
`timescale 1ns/10ps

module scfpt_op_shift
    import scfpt_pkg::*;
(
    input  wire logic     serial_clock_line,
    input  wire logic     arst_n,
    input  wire logic     flash_select_low,
    input  wire logic     serial_data_in,
    scfpt_op_if.producer  opif
);

    typedef struct packed {
        logic [3:0] bits;
        logic [6:0] shift;
    } scfpt_fr_s;

    typedef struct packed {
        logic [7:0] opcode;
        logic       valid;
    } scfpt_hold_s;

    scfpt_fr_s   fr_reg;
    scfpt_fr_s   fr_next;
    scfpt_hold_s hold_reg;
    scfpt_hold_s hold_next;
    logic        frame_rst_n;

    // Bit count restarts with every frame, clock or no clock
    assign frame_rst_n = arst_n & ~flash_select_low;

    always_comb
    begin
        fr_next   = fr_reg;
        hold_next = hold_reg;
        if (fr_reg.bits < OP_BITS)
        begin
            fr_next.bits  = fr_reg.bits + 4'h1;
            fr_next.shift = {fr_reg.shift[5:0], serial_data_in};
        end
        if (fr_reg.bits == 4'h0)
            hold_next.valid = 1'b0;
        if (fr_reg.bits == OP_BITS - 4'h1)
        begin
            hold_next.opcode = {fr_reg.shift, serial_data_in};
            hold_next.valid  = 1'b1;
        end
    end

    always_ff @(posedge serial_clock_line or negedge frame_rst_n)
        if (!frame_rst_n)
            fr_reg <= '0;
        else
            fr_reg <= fr_next;

    // Held word survives deselect so the system side can take it
    always_ff @(posedge serial_clock_line or negedge arst_n)
        if (!arst_n)
            hold_reg <= '0;
        else
            hold_reg <= hold_next;

    assign opif.opcode = hold_reg.opcode;
    assign opif.valid  = hold_reg.valid;

endmodule : scfpt_op_shift

// ---- hdl/scfpt_cycle_timer.sv ----
/*
 * Down-counter timing one self-timed cycle in system clocks.
 * Assumes start is a single-cycle pulse, never while busy.
 */
`timescale 1ns/10ps

module scfpt_cycle_timer
    import scfpt_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   arst_n,
    scfpt_tmr_if.timer  tif
);

    typedef struct packed {
        logic [31:0] cnt;
        logic        busy;
        logic        done;
    } scfpt_tmr_s;

    scfpt_tmr_s t_reg;
    scfpt_tmr_s t_next;

    always_comb
    begin
        t_next      = t_reg;
        t_next.done = 1'b0;
        if (tif.start)
        begin
            t_next.cnt  = tif.load;
            t_next.busy = 1'b1;
        end
        else if (t_reg.busy)
        begin
            t_next.cnt = t_reg.cnt - 32'h1;
            if (t_reg.cnt == 32'h1)
            begin
                t_next.busy = 1'b0;
                t_next.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n)
            t_reg <= '0;
        else
            t_reg <= t_next;

    assign tif.busy = t_reg.busy;
    assign tif.done = t_reg.done;

    property p_load;
        @(posedge clock) disable iff (!arst_n)
        tif.start |=> (t_reg.cnt == $past(tif.load)) && t_reg.busy;
    endproperty
    a_load: assert property (p_load)
        else $error("Timer did not load the requested count");

endmodule : scfpt_cycle_timer

// ---- test/scfpt_host_model.sv ----
/*
 * Host-side model of the configuration controller: frames opcodes
 * onto the serial link and can hold select without clocking.
 * Assumes the flash samples data on the rising serial clock.
 */
`timescale 1ns/10ps

module scfpt_host_model
(
    output logic serial_clock_line,
    output logic flash_select_low,
    output logic serial_data_in
);
    // 6.25 MHz link, below every clock ceiling of the flash
    localparam int HALF = 80;

    // Host-side configuration pins; the flash never drives them
    logic config_status_line    = 1'b1;
    logic config_complete_line  = 1'b0;
    logic reconfig_request_line = 1'b1;

    initial
    begin
        serial_clock_line = 1'b0;
        flash_select_low  = 1'b1;
        serial_data_in    = 1'b0;
    end

    // Clock stands still outside frames; data flips when released
    task automatic frame(input logic [7:0] op, input int nbits);
        #37 flash_select_low = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            serial_data_in = (i < 8) ? op[7 - i] : 1'b0;
            #HALF serial_clock_line = 1'b1;
            #HALF serial_clock_line = 1'b0;
        end
        #HALF flash_select_low = 1'b1;
        serial_data_in = ~serial_data_in;
        #500;
    endtask : frame

    task automatic select_hold(input int ns);
        #37 flash_select_low = 1'b0;
        #ns flash_select_low = 1'b1;
        serial_data_in = ~serial_data_in;
        #500;
    endtask : select_hold

    // Error restart: status pulse, then a select pulse to the flash
    task automatic config_error(input logic auto_restart);
        config_status_line = 1'b0;
        if (!config_status_line || !config_complete_line)
        begin
            if (!auto_restart)
            begin
                #200 reconfig_request_line = 1'b0;
                #200 reconfig_request_line = 1'b1;
            end
            #100 config_status_line = 1'b1;
            select_hold(200);
        end
    endtask : config_error
endmodule : scfpt_host_model

// ---- test/scfpt_flash_seq_tb.sv ----
/*
 * Self-checking bench for the flash sequencer: frames commands
 * through the host model and times the self-timed cycles.
 * Assumes shortened cycle counts handed to the design below.
 */
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    err_count++; $display("wrong value at %0t: %h %h", $time, a, b); \
    end end

module scfpt_flash_seq_tb;
    import scfpt_pkg::*;

    logic       clock;
    logic       arst_n;
    logic       serial_clock_line;
    logic       flash_select_low;
    logic       serial_data_in;
    logic       flash_enabled;
    logic       active_power;
    logic       standby_power;
    logic       write_in_progress;
    logic       write_enable_latch;
    logic [1:0] cycle_kind;
    int         err_count;
    int         checks_done;
    int         hi_cnt;

    // Shortened cycle counts keep the run well inside the watchdog
    localparam int N_PROG = 20;
    localparam int N_WSR  = 30;
    localparam int N_SE   = 40;
    localparam int N_BE   = 50;

    scfpt_flash_seq #(
        .PROG_CYC (N_PROG),
        .WSR_CYC  (N_WSR),
        .SE_CYC   (N_SE),
        .BE_CYC   (N_BE)
    ) DUT (
        .clock              (clock),
        .arst_n             (arst_n),
        .serial_clock_line  (serial_clock_line),
        .flash_select_low   (flash_select_low),
        .serial_data_in     (serial_data_in),
        .flash_enabled      (flash_enabled),
        .active_power       (active_power),
        .standby_power      (standby_power),
        .write_in_progress  (write_in_progress),
        .write_enable_latch (write_enable_latch),
        .cycle_kind         (cycle_kind)
    );

    scfpt_host_model u_host (
        .serial_clock_line (serial_clock_line),
        .flash_select_low  (flash_select_low),
        .serial_data_in    (serial_data_in)
    );

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(negedge clock)
    begin
        if (write_in_progress === 1'b1)
            hi_cnt++;
    end

    task automatic conclude;
        if (err_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    task automatic run_op(input logic [7:0] op, input int n,
                          input logic [1:0] kind);
        u_host.frame(DUT.OPC_WREN, 8);
        @(negedge clock);
        `CHK(write_enable_latch, 1'b1)
        hi_cnt = 0;
        u_host.frame(op, 32);
        @(negedge clock);
        `CHK(write_in_progress, 1'b1)
        `CHK(write_enable_latch, 1'b0)
        `CHK(cycle_kind, kind)
        `CHK(standby_power, 1'b0)
        // Select during a cycle: enabled, but no command taken
        fork
            u_host.select_hold(500);
            begin
                repeat (6) @(negedge clock);
                `CHK(flash_enabled, 1'b1)
            end
        join
        repeat (3) @(negedge clock);
        `CHK(flash_enabled, 1'b0)
        `CHK(active_power, 1'b1)
        for (int k = 0; k < 200 && write_in_progress !== 1'b0; k++)
            @(negedge clock);
        `CHK(write_in_progress, 1'b0)
        `CHK(hi_cnt, n + 2)
        `CHK(standby_power, 1'b1)
        `CHK(active_power, 1'b0)
    endtask : run_op

    initial
    begin
        #400_000;
        err_count++;
        conclude();
    end

    initial
    begin
        err_count   = 0;
        checks_done = 0;
        hi_cnt      = 0;
        arst_n      = 1'b0;
        repeat (16) @(negedge clock);
        `CHK(standby_power, 1'b1)
        `CHK(active_power, 1'b0)
        `CHK(write_in_progress, 1'b0)
        `CHK(cycle_kind, 2'h0)
        arst_n = 1'b1;
        repeat (4) @(negedge clock);
        fork
            u_host.select_hold(1000);
            begin
                repeat (7) @(negedge clock);
                `CHK(flash_enabled, 1'b1)
                `CHK(active_power, 1'b1)
                `CHK(standby_power, 1'b0)
            end
        join
        @(negedge clock);
        `CHK(flash_enabled, 1'b0)
        `CHK(standby_power, 1'b1)
        // Erase without the latch set is refused
        u_host.frame(DUT.OPC_SE, 32);
        repeat (3) @(negedge clock);
        `CHK(write_in_progress, 1'b0)
        // Truncated enable frame is ignored
        u_host.frame(DUT.OPC_WREN, 4);
        @(negedge clock);
        `CHK(write_enable_latch, 1'b0)
        run_op(DUT.OPC_PROG, N_PROG, 2'h0);
        run_op(DUT.OPC_WSR, N_WSR, 2'h1);
        run_op(DUT.OPC_SE, N_SE, 2'h2);
        run_op(DUT.OPC_BE, N_BE, 2'h3);
        u_host.frame(DUT.OPC_WREN, 8);
        u_host.frame(DUT.OPC_WRDI, 8);
        @(negedge clock);
        `CHK(write_enable_latch, 1'b0)
        // Host error restarts pulse select only; flash state is untouched
        u_host.config_error(1'b1);
        u_host.config_error(1'b0);
        @(negedge clock);
        `CHK(write_enable_latch, 1'b0)
        `CHK(write_in_progress, 1'b0)
        `CHK(standby_power, 1'b1)
        conclude();
    end
endmodule : scfpt_flash_seq_tb
